// *** design/paa_pkg.sv ***
// shared types and constants for the accumulator arithmetic unit
package paa_pkg;

    // instruction codes handled by the unit
    typedef enum logic [2:0] {
        multiply_binary_op    = 3'h0,
        divide_binary_op      = 3'h1,
        increment_binary_op   = 3'h2,
        decrement_binary_op   = 3'h3,
        add_formatted_op      = 3'h4,
        subtract_formatted_op = 3'h5
    } paa_opcode_t;

    // one instruction as offered by the sequencer
    typedef struct packed {
        paa_opcode_t opcode;      // what to do
        logic        src_const;   // multiply/divide: use konst instead of word memory
        logic        indirect;    // word_addr names a pointer word
        logic [15:0] word_addr;   // word memory location or pointer location
        logic [15:0] konst;       // constant operand 0..FFFF
        logic [15:0] bit_addr;    // first discrete bit of the run
        logic [5:0]  bit_count;   // run length 1..32
    } paa_instr_t;

    // status flag set
    typedef struct packed {
        logic divide_overflow_flag;
        logic zero_result_flag;
        logic borrow16_flag;
        logic borrow32_flag;
        logic carry16_flag;
        logic carry32_flag;
        logic negative_result_flag;
        logic bcd_error_flag;
    } paa_flags_t;

    // sticky interrupt events
    typedef struct packed {
        logic bad_count;
        logic bcd_error;
        logic div_overflow;
        logic done;
    } paa_events_t;

    // register offsets, byte addresses
    localparam logic [7:0] PAA_REG_ACC        = 8'h00;
    localparam logic [7:0] PAA_REG_FLAGS      = 8'h04;
    localparam logic [7:0] PAA_REG_STACK1     = 8'h08;
    localparam logic [7:0] PAA_REG_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] PAA_REG_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] PAA_REG_IRQ_CLEAR  = 8'h14;

    // reset values and counts
    localparam logic [31:0] PAA_ACC_RESET   = 32'h0000_0000;
    localparam logic [7:0]  PAA_FLAGS_RESET = 8'h00;
    localparam logic [3:0]  PAA_IRQ_RESET   = 4'h0;
    localparam logic [5:0]  PAA_BITS_MAX    = 6'h20;
    localparam logic [4:0]  PAA_DIV_STEPS   = 5'h1F;  // last index of 32 steps
    localparam int          PAA_BCD_DIGITS  = 8;

endpackage : paa_pkg

// *** design/paa_arith_unit.sv ***
// accumulator arithmetic unit: binary multiply/divide/inc/dec, formatted bcd add/sub
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module paa_arith_unit #(
    parameter int WORD_AW = 16,
    parameter int BIT_AW  = 16
) (
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    // instruction sequencer
    input  wire logic                op_valid_in,
    input  wire paa_pkg::paa_instr_t op_in,
    output logic                     op_ready_out,
    output logic                     op_done_out,
    input  wire logic                acc_load_in,
    input  wire logic [31:0]         acc_load_data_in,
    output logic [31:0]              acc_out,
    output paa_pkg::paa_flags_t      flags_out,
    // word memory
    output logic                     mem_rd_out,
    output logic                     mem_wr_out,
    output logic [WORD_AW-1:0]       mem_addr_out,
    output logic [15:0]              mem_wr_data_out,
    input  wire logic [15:0]         mem_rd_data_in,
    // discrete bit memory
    output logic                     bit_rd_out,
    output logic [BIT_AW-1:0]        bit_addr_out,
    input  wire logic                bit_rd_data_in,
    // accumulator stack level one
    output logic                     stack_wr_out,
    output logic [31:0]              stack_data_out,
    // register port
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [31:0]         reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic [31:0]              reg_rdata_out,
    output logic                     irq_out
);
    import paa_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE, S_PTR, S_PTR_WAIT, S_WORD, S_WORD_WAIT, S_BIT, S_BIT_WAIT, S_DIV, S_EXEC
    } paa_state_t;

    // bcd adder: sum, carry out of digit 3, carry out of digit 7
    function automatic logic [33:0] paa_bcd_add(input logic [31:0] a, input logic [31:0] b);
        logic [4:0]  d;
        logic        c;
        logic        c16;
        logic [31:0] s;
        c   = 1'b0;
        c16 = 1'b0;
        s   = 32'h0000_0000;
        for (int i = 0; i < PAA_BCD_DIGITS; i++) begin
            d = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
            c = (d > 5'h09);
            if (c) begin
                d = d + 5'h06;
            end
            s[4*i +: 4] = d[3:0];
            if (i == 3) begin
                c16 = c;
            end
        end
        return {c, c16, s};
    endfunction : paa_bcd_add

    // bcd subtractor: difference, borrow out of digit 3, borrow out of digit 7
    function automatic logic [33:0] paa_bcd_sub(input logic [31:0] a, input logic [31:0] b);
        logic [4:0]  d;
        logic        br;
        logic        br16;
        logic [31:0] s;
        br   = 1'b0;
        br16 = 1'b0;
        s    = 32'h0000_0000;
        for (int i = 0; i < PAA_BCD_DIGITS; i++) begin
            d  = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, br};
            br = d[4];
            if (br) begin
                d = d + 5'h0A;
            end
            s[4*i +: 4] = d[3:0];
            if (i == 3) begin
                br16 = br;
            end
        end
        return {br, br16, s};
    endfunction : paa_bcd_sub

    // true when any nibble is above nine
    function automatic logic paa_not_bcd(input logic [31:0] v);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < PAA_BCD_DIGITS; i++) begin
            bad = bad | (v[4*i +: 4] > 4'h9);
        end
        return bad;
    endfunction : paa_not_bcd

    paa_state_t           state_r,   state_nxt;
    paa_instr_t           instr_r,   instr_nxt;
    logic [31:0]          acc_r,     acc_nxt;
    paa_flags_t           flags_r,   flags_nxt;
    logic [31:0]          opnd_r,    opnd_nxt;
    logic [WORD_AW-1:0]   addr_r,    addr_nxt;
    logic [BIT_AW-1:0]    baddr_r,   baddr_nxt;
    logic [5:0]           bidx_r,    bidx_nxt;
    logic [31:0]          quo_r,     quo_nxt;
    logic [16:0]          rem_r,     rem_nxt;
    logic [4:0]           dcnt_r,    dcnt_nxt;
    logic                 done_r,    done_nxt;
    logic                 mwr_r,     mwr_nxt;
    logic [15:0]          mwd_r,     mwd_nxt;
    logic                 swr_r,     swr_nxt;
    logic [31:0]          sdat_r,    sdat_nxt;
    paa_events_t          ev_set;
    paa_events_t          irq_st_r,  irq_st_nxt;
    paa_events_t          irq_en_r,  irq_en_nxt;
    logic [31:0]          rdata_r,   rdata_nxt;

    logic [31:0]          product;
    logic [33:0]          bcd_sum;
    logic [33:0]          bcd_dif;
    logic                 bcd_bad;
    logic [16:0]          trial;
    logic [15:0]          word_res;

    // datapath terms
    assign product  = 32'(acc_r[15:0] * opnd_r[15:0]);
    assign bcd_sum  = paa_bcd_add(acc_r, opnd_r);
    assign bcd_dif  = paa_bcd_sub(acc_r, opnd_r);
    assign bcd_bad  = paa_not_bcd(acc_r) | paa_not_bcd(opnd_r);
    assign trial    = {rem_r[15:0], quo_r[31]} - {1'b0, opnd_r[15:0]};
    assign word_res = (instr_r.opcode == increment_binary_op) ?
                      16'(opnd_r[15:0] + 16'h0001) :
                      16'(opnd_r[15:0] - 16'h0001);

    // sequencer, datapath and flag next values
    always_comb begin
        state_nxt = state_r;
        instr_nxt = instr_r;
        acc_nxt   = acc_r;
        flags_nxt = flags_r;
        opnd_nxt  = opnd_r;
        addr_nxt  = addr_r;
        baddr_nxt = baddr_r;
        bidx_nxt  = bidx_r;
        quo_nxt   = quo_r;
        rem_nxt   = rem_r;
        dcnt_nxt  = dcnt_r;
        done_nxt  = 1'b0;
        mwr_nxt   = 1'b0;
        mwd_nxt   = mwd_r;
        swr_nxt   = 1'b0;
        sdat_nxt  = sdat_r;
        ev_set    = '0;
        case (state_r)
            S_IDLE: begin
                if (op_valid_in) begin
                    instr_nxt = op_in;
                    addr_nxt  = op_in.word_addr[WORD_AW-1:0];
                    baddr_nxt = op_in.bit_addr[BIT_AW-1:0];
                    bidx_nxt  = 6'h00;
                    opnd_nxt  = {16'h0000, op_in.konst};
                    if (op_in.opcode == add_formatted_op ||
                        op_in.opcode == subtract_formatted_op) begin
                        opnd_nxt = 32'h0000_0000;
                        if (op_in.bit_count == 6'h00 || op_in.bit_count > PAA_BITS_MAX) begin
                            ev_set.bad_count = 1'b1;         // refused, accumulator and flags unchanged
                            done_nxt         = 1'b1;
                        end else begin
                            state_nxt = S_BIT;
                        end
                    end else if ((op_in.opcode == multiply_binary_op ||
                                  op_in.opcode == divide_binary_op) && op_in.src_const) begin
                        state_nxt = S_EXEC;
                        if (op_in.opcode == divide_binary_op) begin
                            state_nxt = S_DIV;
                        end
                    end else begin
                        state_nxt = op_in.indirect ? S_PTR : S_WORD;
                    end
                end else if (acc_load_in) begin
                    acc_nxt = acc_load_data_in;
                end
                quo_nxt  = acc_nxt;
                rem_nxt  = 17'h00000;
                dcnt_nxt = 5'h00;
            end
            S_PTR: begin
                state_nxt = S_PTR_WAIT;
            end
            S_PTR_WAIT: begin
                addr_nxt  = mem_rd_data_in[WORD_AW-1:0];         // pointer target
                state_nxt = S_WORD;
            end
            S_WORD: begin
                state_nxt = S_WORD_WAIT;
            end
            S_WORD_WAIT: begin
                opnd_nxt  = {16'h0000, mem_rd_data_in};
                state_nxt = (instr_r.opcode == divide_binary_op) ? S_DIV : S_EXEC;
            end
            S_BIT: begin
                state_nxt = S_BIT_WAIT;
            end
            S_BIT_WAIT: begin
                opnd_nxt[bidx_r[4:0]] = bit_rd_data_in;
                bidx_nxt  = 6'(bidx_r + 6'h01);
                baddr_nxt = BIT_AW'(baddr_r + 1'b1);
                state_nxt = (bidx_nxt == instr_r.bit_count) ? S_EXEC : S_BIT;
            end
            S_DIV: begin
                // one restoring step per cycle, 32 steps
                if (opnd_r[15:0] == 16'h0000) begin
                    state_nxt = S_EXEC;
                end else begin
                    quo_nxt  = {quo_r[30:0], ~trial[16]};
                    rem_nxt  = trial[16] ? {rem_r[15:0], quo_r[31]} : trial;
                    dcnt_nxt = 5'(dcnt_r + 5'h01);
                    if (dcnt_r == PAA_DIV_STEPS) begin
                        state_nxt = S_EXEC;
                    end
                end
            end
            S_EXEC: begin
                done_nxt  = 1'b1;
                state_nxt = S_IDLE;
                case (instr_r.opcode)
                    multiply_binary_op: begin
                        acc_nxt                        = product;
                        flags_nxt.zero_result_flag     = (product == 32'h0000_0000);
                        flags_nxt.negative_result_flag = product[31];
                    end
                    divide_binary_op: begin
                        flags_nxt.divide_overflow_flag = (opnd_r[15:0] == 16'h0000);
                        ev_set.div_overflow            = flags_nxt.divide_overflow_flag;
                        if (!flags_nxt.divide_overflow_flag) begin
                            acc_nxt  = quo_r;
                            swr_nxt  = 1'b1;
                            sdat_nxt = {16'h0000, rem_r[15:0]};
                        end
                        flags_nxt.zero_result_flag     = (acc_nxt == 32'h0000_0000);
                        flags_nxt.negative_result_flag = acc_nxt[31];
                    end
                    increment_binary_op, decrement_binary_op: begin
                        mwr_nxt                    = 1'b1;
                        mwd_nxt                    = word_res;
                        flags_nxt.zero_result_flag = (word_res == 16'h0000);
                    end
                    add_formatted_op: begin
                        acc_nxt                        = bcd_sum[31:0];
                        flags_nxt.carry16_flag         = bcd_sum[32];
                        flags_nxt.carry32_flag         = bcd_sum[33];
                        flags_nxt.zero_result_flag     = (bcd_sum[31:0] == 32'h0000_0000);
                        flags_nxt.negative_result_flag = 1'b0;
                        flags_nxt.bcd_error_flag       = bcd_bad;
                        ev_set.bcd_error               = bcd_bad;
                    end
                    subtract_formatted_op: begin
                        acc_nxt                        = bcd_dif[31:0];
                        flags_nxt.borrow16_flag        = bcd_dif[32];
                        flags_nxt.borrow32_flag        = bcd_dif[33];
                        flags_nxt.zero_result_flag     = (bcd_dif[31:0] == 32'h0000_0000);
                        flags_nxt.negative_result_flag = bcd_dif[33];
                        flags_nxt.bcd_error_flag       = bcd_bad;
                        ev_set.bcd_error               = bcd_bad;
                    end
                    default: begin
                        done_nxt = 1'b1;
                    end
                endcase
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        ev_set.done = done_nxt;
    end

    // register port next values: sticky status, set wins over clear
    always_comb begin
        irq_st_nxt = irq_st_r;
        irq_en_nxt = irq_en_r;
        rdata_nxt  = 32'h0000_0000;
        if (reg_wr_in) begin
            if (reg_addr_in == PAA_REG_IRQ_ENABLE) begin
                irq_en_nxt = reg_wdata_in[3:0];
            end else if (reg_addr_in == PAA_REG_IRQ_CLEAR) begin
                irq_st_nxt = irq_st_r & ~reg_wdata_in[3:0];
            end
        end
        irq_st_nxt = irq_st_nxt | ev_set;
        if (reg_rd_in) begin
            if (reg_addr_in == PAA_REG_ACC) begin
                rdata_nxt = acc_r;
            end else if (reg_addr_in == PAA_REG_FLAGS) begin
                rdata_nxt = {24'h000000, flags_r};
            end else if (reg_addr_in == PAA_REG_STACK1) begin
                rdata_nxt = sdat_r;
            end else if (reg_addr_in == PAA_REG_IRQ_STATUS) begin
                rdata_nxt = {28'h0000000, irq_st_r};
            end else if (reg_addr_in == PAA_REG_IRQ_ENABLE) begin
                rdata_nxt = {28'h0000000, irq_en_r};
            end else begin
                rdata_nxt = 32'h0000_0000;               // unmapped and clear read zero
            end
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_r  <= S_IDLE;
            instr_r  <= '0;
            acc_r    <= PAA_ACC_RESET;
            flags_r  <= PAA_FLAGS_RESET;
            opnd_r   <= 32'h0000_0000;
            addr_r   <= '0;
            baddr_r  <= '0;
            bidx_r   <= 6'h00;
            quo_r    <= 32'h0000_0000;
            rem_r    <= 17'h00000;
            dcnt_r   <= 5'h00;
            done_r   <= 1'b0;
            mwr_r    <= 1'b0;
            mwd_r    <= 16'h0000;
            swr_r    <= 1'b0;
            sdat_r   <= 32'h0000_0000;
            irq_st_r <= PAA_IRQ_RESET;
            irq_en_r <= PAA_IRQ_RESET;
            rdata_r  <= 32'h0000_0000;
        end else begin
            state_r  <= state_nxt;
            instr_r  <= instr_nxt;
            acc_r    <= acc_nxt;
            flags_r  <= flags_nxt;
            opnd_r   <= opnd_nxt;
            addr_r   <= addr_nxt;
            baddr_r  <= baddr_nxt;
            bidx_r   <= bidx_nxt;
            quo_r    <= quo_nxt;
            rem_r    <= rem_nxt;
            dcnt_r   <= dcnt_nxt;
            done_r   <= done_nxt;
            mwr_r    <= mwr_nxt;
            mwd_r    <= mwd_nxt;
            swr_r    <= swr_nxt;
            sdat_r   <= sdat_nxt;
            irq_st_r <= irq_st_nxt;
            irq_en_r <= irq_en_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // outputs
    assign op_ready_out    = (state_r == S_IDLE);
    assign op_done_out     = done_r;
    assign acc_out         = acc_r;
    assign flags_out       = flags_r;
    assign mem_rd_out      = (state_r == S_PTR) || (state_r == S_WORD);
    assign mem_wr_out      = mwr_r;
    assign mem_addr_out    = addr_r;
    assign mem_wr_data_out = mwd_r;
    assign bit_rd_out      = (state_r == S_BIT);
    assign bit_addr_out    = baddr_r;
    assign stack_wr_out    = swr_r;
    assign stack_data_out  = sdat_r;
    assign reg_rdata_out   = rdata_r;
    assign irq_out         = |(irq_st_r & irq_en_r);

endmodule : paa_arith_unit

// *** sim/paa_arith_unit_assertions.sv ***
// port checker for the accumulator arithmetic unit
`timescale 1ns/1ps
module paa_arith_unit_assertions (
    input wire logic                clk_in,
    input wire logic                rst_b_in,
    input wire logic                op_valid_in,
    input wire paa_pkg::paa_instr_t op_in,
    input wire logic                op_ready_out,
    input wire logic                op_done_out,
    input wire logic                acc_load_in,
    input wire logic [31:0]         acc_out,
    input wire paa_pkg::paa_flags_t flags_out,
    input wire logic                mem_wr_out,
    input wire logic [15:0]         mem_wr_data_out,
    input wire logic [15:0]         mem_rd_data_in,
    input wire logic                stack_wr_out,
    input wire logic [31:0]         stack_data_out
);
    import paa_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    paa_opcode_t op_r;
    logic        take;
    logic        bin;
    // opcode of the instruction in flight
    assign take = op_valid_in && op_ready_out;
    assign bin = op_r inside {multiply_binary_op, divide_binary_op};
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) op_r <= increment_binary_op;
        else if (take) op_r <= op_in.opcode;
    end
    property p_mul;
        take && op_in.opcode == multiply_binary_op && op_in.src_const |-> ##2 op_done_out
            && acc_out == {16'h0, $past(acc_out[15:0], 2)} * {16'h0, $past(op_in.konst, 2)};
    endproperty
    a_mul: assert property (p_mul) else $error("multiply product");
    property p_dz;
        take && op_in.opcode == divide_binary_op && op_in.src_const && op_in.konst == 16'h0
            |-> ##3 op_done_out && flags_out.divide_overflow_flag && acc_out == $past(acc_out, 3);
    endproperty
    a_dz: assert property (p_dz) else $error("divide by zero");
    property p_stk;
        stack_wr_out |-> op_done_out && op_r == divide_binary_op && stack_data_out[31:16] == 16'h0;
    endproperty
    a_stk: assert property (p_stk) else $error("remainder write");
    property p_zero;
        op_done_out && bin && !flags_out.divide_overflow_flag
            |-> flags_out.zero_result_flag == (acc_out == 32'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag");
    property p_neg;
        op_done_out && bin |-> flags_out.negative_result_flag == acc_out[31];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag");
    property p_inc;
        mem_wr_out && op_r == increment_binary_op
            |-> mem_wr_data_out == $past(mem_rd_data_in, 2) + 16'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("increment value");
    property p_dec;
        mem_wr_out && op_r == decrement_binary_op
            |-> mem_wr_data_out == $past(mem_rd_data_in, 2) - 16'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("decrement value");
    property p_step;
        take && op_in.opcode inside {increment_binary_op, decrement_binary_op}
            |=> ($stable(acc_out) && $stable({flags_out[7], flags_out[5:0]}))[*4];
    endproperty
    a_step: assert property (p_step) else $error("step touched state");
    property p_hold;
        !op_done_out && !$past(acc_load_in) |-> $stable(flags_out);
    endproperty
    a_hold: assert property (p_hold) else $error("flags moved");
endmodule : paa_arith_unit_assertions
bind paa_arith_unit paa_arith_unit_assertions i_chk (.clk_in, .rst_b_in, .op_valid_in, .op_in,
    .op_ready_out, .op_done_out, .acc_load_in, .acc_out, .flags_out, .mem_wr_out,
    .mem_wr_data_out, .mem_rd_data_in, .stack_wr_out, .stack_data_out);

// *** sim/paa_mem_model.sv ***
// word memory and discrete bit memory beside the arithmetic unit
`timescale 1ns/1ps
module paa_mem_model (
    input  wire logic        clk_in,
    input  wire logic        mem_rd_in,
    input  wire logic        mem_wr_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [15:0] mem_wr_data_in,
    output logic      [15:0] mem_rd_data_out = 16'h0,
    input  wire logic        bit_rd_in,
    input  wire logic [15:0] bit_addr_in,
    output logic             bit_rd_data_out = 1'b0
);
    logic [15:0] words [0:255];
    logic        bits  [0:255];
    // answer a cycle after the pulse, toggle otherwise so stale data never looks valid
    always @(posedge clk_in) begin
        mem_rd_data_out <= mem_rd_in ? words[mem_addr_in[7:0]] : ~mem_rd_data_out;
        bit_rd_data_out <= bit_rd_in ? bits[bit_addr_in[7:0]] : ~bit_rd_data_out;
        if (mem_wr_in) words[mem_addr_in[7:0]] <= mem_wr_data_in;
    end
endmodule : paa_mem_model

// *** sim/paa_arith_unit_tb.sv ***
// self-checking bench for the accumulator arithmetic unit
`timescale 1ns/1ps
module paa_arith_unit_tb;
    import paa_pkg::*;
    logic        clk_in = 1'b0, rst_b_in = 1'b0, op_valid_in = 1'b0, acc_load_in = 1'b0;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    paa_instr_t  op_in = '0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] acc_load_data_in = 32'h0, reg_wdata_in = 32'h0;
    logic        op_ready_out, op_done_out, mem_rd_out, mem_wr_out, bit_rd_out, bit_rd_data_in;
    logic        stack_wr_out, irq_out;
    logic [15:0] mem_addr_out, mem_wr_data_out, mem_rd_data_in, bit_addr_out;
    logic [31:0] acc_out, stack_data_out, reg_rdata_out, v;
    paa_flags_t  flags_out;
    int          errors = 0, checked = 0, cyc = 0;
    always #4 clk_in = ~clk_in;
    paa_arith_unit i_dut (.clk_in, .rst_b_in, .op_valid_in, .op_in, .op_ready_out, .op_done_out,
        .acc_load_in, .acc_load_data_in, .acc_out, .flags_out, .mem_rd_out, .mem_wr_out,
        .mem_addr_out, .mem_wr_data_out, .mem_rd_data_in, .bit_rd_out, .bit_addr_out,
        .bit_rd_data_in, .stack_wr_out, .stack_data_out, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out);
    paa_mem_model i_mem (.clk_in, .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
        .mem_addr_in(mem_addr_out), .mem_wr_data_in(mem_wr_data_out),
        .mem_rd_data_out(mem_rd_data_in), .bit_rd_in(bit_rd_out), .bit_addr_in(bit_addr_out),
        .bit_rd_data_out(bit_rd_data_in));
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic results;
        if (errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // offer one instruction, wait for its done pulse
    task automatic run(input paa_opcode_t o, input logic s, p, input logic [15:0] a, k,
                       input logic [5:0] n);
        int t;
        t = 0;
        @(posedge clk_in);
        op_in <= '{o, s, p, a, k, 16'h0010, n};
        op_valid_in <= 1'b1;
        do begin
            @(posedge clk_in);
            op_valid_in <= 1'b0;
            #1 t++;
        end while (op_done_out !== 1'b1 && t < 100);
        chk("done", 1'b1, op_done_out);
    endtask : run
    task automatic load(input logic [31:0] d);
        @(posedge clk_in);
        acc_load_in <= 1'b1;
        acc_load_data_in <= d;
        @(posedge clk_in);
        acc_load_in <= 1'b0;
    endtask : load
    // one register write or read, read data lands in v
    task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
    endtask : reg_io
    task automatic t_mul;
        load(32'hFFFF_1234);
        run(multiply_binary_op, 1'b1, 1'b0, 16'h0, 16'h0100, 6'h01);
        chk("product", 32'h0012_3400, acc_out);
        load(32'h0000_FFFF);
        run(multiply_binary_op, 1'b1, 1'b0, 16'h0, 16'hFFFF, 6'h01);
        chk("negative", 1'b1, flags_out.negative_result_flag);
        run(multiply_binary_op, 1'b1, 1'b0, 16'h0, 16'h0000, 6'h01);
        chk("zero", 1'b1, flags_out.zero_result_flag);
    endtask : t_mul
    task automatic t_div;
        i_mem.words[5] = 16'h0007;
        i_mem.words[6] = 16'h0005;
        load(32'h0001_86A0);
        run(divide_binary_op, 1'b0, 1'b0, 16'h0005, 16'h0, 6'h01);
        chk("quotient", 32'h0000_37CD, acc_out);
        reg_io(1'b0, PAA_REG_STACK1, 32'h0);
        chk("remainder", 32'h5, v);
        run(divide_binary_op, 1'b0, 1'b1, 16'h0006, 16'h0, 6'h01);
        chk("pointer quotient", 32'h0000_07F8, acc_out);
        run(divide_binary_op, 1'b1, 1'b0, 16'h0, 16'h0000, 6'h01);
        chk("overflow", 1'b1, flags_out.divide_overflow_flag);
        chk("kept", 32'h0000_07F8, acc_out);
    endtask : t_div
    task automatic t_step;
        i_mem.words[2] = 16'h0010;
        i_mem.words[16] = 16'hFFFF;
        i_mem.words[3] = 16'h0000;
        run(increment_binary_op, 1'b0, 1'b1, 16'h0002, 16'h0, 6'h01);
        chk("inc zero", 1'b1, flags_out.zero_result_flag);
        run(decrement_binary_op, 1'b0, 1'b0, 16'h0003, 16'h0, 6'h01);
        chk("dec zero", 1'b0, flags_out.zero_result_flag);
        @(posedge clk_in);
        #1 chk("inc word", 32'h0, i_mem.words[16]);
        chk("dec word", 32'h0000_FFFF, i_mem.words[3]);
    endtask : t_step
    task automatic t_bcd;
        for (int i = 0; i < 32; i++) i_mem.bits[16 + i] = i inside {0, 28};
        load(32'h0000_9999);
        run(add_formatted_op, 1'b0, 1'b0, 16'h0, 16'h0, 6'h10);
        chk("bcd sum", 32'h0001_0000, acc_out);
        chk("carries", 32'h2, {flags_out.carry16_flag, flags_out.carry32_flag});
        load(32'h0);
        run(subtract_formatted_op, 1'b0, 1'b0, 16'h0, 16'h0, 6'h01);
        chk("bcd diff", 32'h9999_9999, acc_out);
        chk("borrows", 32'h7, {flags_out[5:4], flags_out.negative_result_flag});
        chk("held", 1'b1, flags_out.carry16_flag);
        load(32'h8999_9999);
        run(add_formatted_op, 1'b0, 1'b0, 16'h0, 16'h0, 6'h20);
        chk("wide", 32'h6, {flags_out[6], flags_out[2], flags_out[0]});
        load(32'h0000_000A);
        run(add_formatted_op, 1'b0, 1'b0, 16'h0, 16'h0, 6'h04);
        chk("bcd error", 1'b1, flags_out.bcd_error_flag);
    endtask : t_bcd
    task automatic t_irq;
        reg_io(1'b1, PAA_REG_IRQ_ENABLE, 32'h2);
        run(add_formatted_op, 1'b0, 1'b0, 16'h0, 16'h0, 6'h00);
        reg_io(1'b0, PAA_REG_IRQ_STATUS, 32'h0);
        chk("status", 32'hF, v);
        chk("irq on", 1'b1, irq_out);
        reg_io(1'b1, PAA_REG_IRQ_CLEAR, 32'hF);
        reg_io(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, v);
        chk("irq off", 1'b0, irq_out);
        run(multiply_binary_op, 1'b1, 1'b0, 16'h0, 16'h0001, 6'h01);
        reg_io(1'b0, PAA_REG_IRQ_ENABLE, 32'h0);
        chk("enable", 32'h2, v);
        chk("masked", 1'b0, irq_out);
    endtask : t_irq
    // main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_mul();
        t_div();
        t_step();
        t_bcd();
        t_irq();
        results();
    end
    // hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            results();
        end
    end
endmodule : paa_arith_unit_tb
